// [rtl/gpio_exp_params.svh]
// Register indices, reset values and address constants of the I/O expander
`ifndef GPIO_EXP_PARAMS_SVH
`define GPIO_EXP_PARAMS_SVH
`define IDX_IN0      5'h00
`define IDX_IN1      5'h01
`define IDX_OUT0     5'h02
`define IDX_OUT1     5'h03
`define IDX_POL0     5'h04
`define IDX_POL1     5'h05
`define IDX_DIR0     5'h06
`define IDX_DIR1     5'h07
`define IDX_DRV0     5'h08
`define IDX_DRV1     5'h09
`define IDX_DRV2     5'h0A
`define IDX_DRV3     5'h0B
`define IDX_LAT0     5'h0C
`define IDX_LAT1     5'h0D
`define IDX_PEN0     5'h0E
`define IDX_PEN1     5'h0F
`define IDX_PSEL0    5'h10
`define IDX_PSEL1    5'h11
`define IDX_MSK0     5'h12
`define IDX_MSK1     5'h13
`define IDX_STA0     5'h14
`define IDX_STA1     5'h15
`define IDX_OCFG     5'h16
`define IDX_LAST     5'h16
`define RST_DIR      16'hFFFF
`define RST_MASK     16'hFFFF
`define RST_DRV      32'hFFFFFFFF
`define RST_PSEL     16'hFFFF
`define BUS_ADDR_HI  6'h10
`define SYNC_RST     20'h30000
`endif

// [rtl/gpio_exp_pkg.sv]
// Shared types of the I/O expander
`default_nettype none
package gpio_exp_pkg;
   typedef logic [4:0] reg_idx_t;
   typedef enum logic [2:0]
   {
      T_IDLE = 3'b000,
      T_ADDR = 3'b001,
      T_AACK = 3'b010,
      T_WR   = 3'b011,
      T_WACK = 3'b100,
      T_RD   = 3'b101,
      T_RACK = 3'b110
   } tgt_state_t;
endpackage
`default_nettype wire

// [rtl/pin_sync.sv]
// Two-flop synchroniser for levels arriving from outside the core clock
`default_nettype none
module pin_sync
#(
   parameter int                 WIDTH     = 20,
   parameter logic [WIDTH-1:0]   RESET_VAL = '0
)
(
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         meta_reg <= RESET_VAL;
         q_out    <= RESET_VAL;
      end
      else
      begin
         meta_reg <= d_in;
         q_out    <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// [rtl/serial_target.sv]
// Two-wire serial target: address match, register pointer, byte reads and writes
`include "gpio_exp_params.svh"
`default_nettype none
module serial_target
(
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   input  wire logic              scl_in,
   input  wire logic              sda_in,
   input  wire logic              addr_sel_in,
   input  wire logic [7:0]        rd_data_in,
   output logic                   sda_oe_out,
   output gpio_exp_pkg::reg_idx_t ptr_out,
   output gpio_exp_pkg::reg_idx_t stb_idx_out,
   output logic                   wr_stb_out,
   output logic                   rd_stb_out,
   output logic [7:0]             stb_dat_out
);
   import gpio_exp_pkg::*;

   tgt_state_t state_reg;
   logic       scl_d_reg;
   logic       sda_d_reg;
   logic [7:0] sh_reg;
   logic [7:0] tx_reg;
   logic [3:0] cnt_reg;
   logic       rw_reg;
   logic       first_reg;
   logic       nack_reg;
   logic       scl_rise;
   logic       scl_fall;
   logic       start;
   logic       stop;
   logic       hit;

   assign scl_rise = scl_in & ~scl_d_reg;
   assign scl_fall = ~scl_in & scl_d_reg;
   assign start    = scl_in & scl_d_reg & sda_d_reg & ~sda_in;
   assign stop     = scl_in & scl_d_reg & ~sda_d_reg & sda_in;
   assign hit      = sh_reg[7:1] == {`BUS_ADDR_HI, addr_sel_in};

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end
      else
      begin
         scl_d_reg <= scl_in;
         sda_d_reg <= sda_in;
      end
   end

   // Start and stop override any state, so a confused master can always recover
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         state_reg   <= T_IDLE;
         sda_oe_out  <= 1'b0;
         cnt_reg     <= 4'h0;
         sh_reg      <= 8'h00;
         tx_reg      <= 8'h00;
         rw_reg      <= 1'b0;
         first_reg   <= 1'b0;
         nack_reg    <= 1'b0;
         ptr_out     <= 5'h00;
         stb_idx_out <= 5'h00;
         stb_dat_out <= 8'h00;
         wr_stb_out  <= 1'b0;
         rd_stb_out  <= 1'b0;
      end
      else
      begin
         wr_stb_out <= 1'b0;
         rd_stb_out <= 1'b0;
         if (start)
         begin
            state_reg  <= T_ADDR;
            cnt_reg    <= 4'h0;
            sda_oe_out <= 1'b0;
         end
         else if (stop)
         begin
            state_reg  <= T_IDLE;
            sda_oe_out <= 1'b0;
         end
         else if (scl_rise)
         begin
            sh_reg   <= {sh_reg[6:0], sda_in};
            cnt_reg  <= cnt_reg + 4'h1;
            nack_reg <= sda_in;
         end
         else if (scl_fall)
         begin
            case (state_reg)
               T_ADDR:
                  if (cnt_reg == 4'h8)
                  begin
                     state_reg  <= hit ? T_AACK : T_IDLE;
                     sda_oe_out <= hit;
                     rw_reg     <= sh_reg[0];
                     first_reg  <= 1'b1;
                  end
               T_WR:
                  if (cnt_reg == 4'h8)
                  begin
                     state_reg  <= T_WACK;
                     sda_oe_out <= 1'b1;
                     first_reg  <= 1'b0;
                     if (first_reg)
                        ptr_out <= sh_reg[4:0];
                     else
                     begin
                        wr_stb_out  <= 1'b1;
                        stb_idx_out <= ptr_out;
                        stb_dat_out <= sh_reg;
                        ptr_out     <= ptr_out + 5'h01;
                     end
                  end
               T_AACK, T_WACK, T_RACK:
                  if (rw_reg && !(state_reg == T_RACK && nack_reg))
                  begin
                     state_reg   <= T_RD;
                     tx_reg      <= {rd_data_in[6:0], 1'b0};
                     sda_oe_out  <= ~rd_data_in[7];
                     rd_stb_out  <= 1'b1;
                     stb_idx_out <= ptr_out;
                     stb_dat_out <= rd_data_in;
                     ptr_out     <= ptr_out + 5'h01;
                     cnt_reg     <= 4'h0;
                  end
                  else
                  begin
                     state_reg  <= rw_reg ? T_IDLE : T_WR;
                     sda_oe_out <= 1'b0;
                     cnt_reg    <= 4'h0;
                  end
               T_RD:
                  if (cnt_reg == 4'h8)
                  begin
                     state_reg  <= T_RACK;
                     sda_oe_out <= 1'b0;
                  end
                  else
                  begin
                     sda_oe_out <= ~tx_reg[7];
                     tx_reg     <= {tx_reg[6:0], 1'b0};
                  end
               default:
                  state_reg <= state_reg;
            endcase
         end
      end
   end

   sequence addr_hit_s;
      state_reg == T_ADDR && cnt_reg == 4'h8 && hit && scl_fall;
   endsequence

   addr_ack_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      addr_hit_s |=> sda_oe_out && state_reg == T_AACK)
      else $error("address match not acknowledged");

   tgt_reset_a: assert property (@(posedge clk_in) !rst_n_in |=> state_reg == T_IDLE && !sda_oe_out)
      else $error("serial state not idle after reset");
endmodule
`default_nettype wire

// [rtl/gpio_expander.sv]
// Sixteen-line I/O expander core with serial target and APB register access
//
// Implementation choices: the APB slave port and the address map.
`include "gpio_exp_params.svh"
`default_nettype none
module gpio_expander
(
   input  wire logic        CORE_CLK_IN,
   input  wire logic        RST_B_IN,
   input  wire logic        PSEL_IN,
   input  wire logic        PENABLE_IN,
   input  wire logic        PWRITE_IN,
   input  wire logic [7:0]  PADDR_IN,
   input  wire logic [31:0] PWDATA_IN,
   output logic      [31:0] PRDATA_OUT,
   output logic             PREADY_OUT,
   output logic             PSLVERR_OUT,
   input  wire logic        DEV_RST_B_IN,
   input  wire logic        ADDR_SEL_IN,
   input  wire logic        SCL_IN,
   input  wire logic        SDA_IN,
   output logic             SDA_OUT,
   output logic             SDA_OE_OUT,
   input  wire logic [15:0] LINE_IN,
   output logic      [15:0] LINE_OUT,
   output logic      [15:0] LINE_OE_OUT,
   output logic      [31:0] DRIVE_OUT,
   output logic      [15:0] PULL_EN_OUT,
   output logic      [15:0] PULL_UP_OUT,
   output logic             ALERT_OUT,
   output logic             ALERT_OE_OUT
);
   import gpio_exp_pkg::*;

   logic [19:0] sync_q;
   logic        pin_rst_s;
   logic        addr_s;
   logic        scl_s;
   logic        sda_s;
   logic [15:0] line_s;
   logic        rst_n;

   logic [15:0] in_reg;
   logic [15:0] ref_reg;
   logic [15:0] hold_reg;
   logic [15:0] sta_reg;
   logic [15:0] out_reg;
   logic [15:0] pol_reg;
   logic [15:0] dir_reg;
   logic [31:0] drv_reg;
   logic [15:0] lat_reg;
   logic [15:0] pen_reg;
   logic [15:0] psel_reg;
   logic [15:0] msk_reg;
   logic [1:0]  od_reg;
   logic [15:0] eff;
   logic [15:0] diff;

   logic        wr_en [2];
   reg_idx_t    wr_idx [2];
   logic [7:0]  wr_dat [2];
   logic        rd_en [2];
   reg_idx_t    rd_idx [2];
   logic [7:0]  rd_dat [2];

   logic        apb_access;
   logic        apb_commit;
   logic        apb_mapped;
   reg_idx_t    apb_idx;
   reg_idx_t    tgt_ptr;
   reg_idx_t    tgt_idx;
   logic        tgt_wr;
   logic        tgt_rd;
   logic [7:0]  tgt_dat;
   logic        tgt_sda_oe;
   logic [7:0]  tgt_rd_byte;

   // Reset pin, address pin, bus wires and port lines all arrive asynchronously
   pin_sync #(.WIDTH(20), .RESET_VAL(`SYNC_RST)) u_sync
   (
      .clk_in   (CORE_CLK_IN),
      .rst_n_in (RST_B_IN),
      .d_in     ({DEV_RST_B_IN, ADDR_SEL_IN, SCL_IN, SDA_IN, LINE_IN}),
      .q_out    (sync_q)
   );

   assign pin_rst_s = sync_q[19];
   assign addr_s    = sync_q[18];
   assign scl_s     = sync_q[17];
   assign sda_s     = sync_q[16];
   assign line_s    = sync_q[15:0];

   // The synchroniser itself sits outside the pin reset, otherwise it could never leave it
   assign rst_n = RST_B_IN & pin_rst_s;

   // A process, not a port expression, so register updates behind a steady pointer are seen
   always_comb tgt_rd_byte = reg_byte(tgt_ptr);

   serial_target u_tgt
   (
      .clk_in      (CORE_CLK_IN),
      .rst_n_in    (rst_n),
      .scl_in      (scl_s),
      .sda_in      (sda_s),
      .addr_sel_in (addr_s),
      .rd_data_in  (tgt_rd_byte),
      .sda_oe_out  (tgt_sda_oe),
      .ptr_out     (tgt_ptr),
      .stb_idx_out (tgt_idx),
      .wr_stb_out  (tgt_wr),
      .rd_stb_out  (tgt_rd),
      .stb_dat_out (tgt_dat)
   );

   function automatic logic [7:0] reg_byte(input reg_idx_t idx);
      logic [7:0] b;
      b = 8'h00;
      case (idx)
         `IDX_IN0, `IDX_IN1:   b = in_reg[{idx[0], 3'b000} +: 8];
         `IDX_OUT0, `IDX_OUT1: b = out_reg[{idx[0], 3'b000} +: 8];
         `IDX_POL0, `IDX_POL1: b = pol_reg[{idx[0], 3'b000} +: 8];
         `IDX_DIR0, `IDX_DIR1: b = dir_reg[{idx[0], 3'b000} +: 8];
         `IDX_DRV0, `IDX_DRV1,
         `IDX_DRV2, `IDX_DRV3: b = drv_reg[{idx[1:0], 3'b000} +: 8];
         `IDX_LAT0, `IDX_LAT1: b = lat_reg[{idx[0], 3'b000} +: 8];
         `IDX_PEN0, `IDX_PEN1: b = pen_reg[{idx[0], 3'b000} +: 8];
         `IDX_PSEL0, `IDX_PSEL1: b = psel_reg[{idx[0], 3'b000} +: 8];
         `IDX_MSK0, `IDX_MSK1: b = msk_reg[{idx[0], 3'b000} +: 8];
         `IDX_STA0, `IDX_STA1: b = sta_reg[{idx[0], 3'b000} +: 8];
         `IDX_OCFG:            b = {6'h00, od_reg};
         default:              b = 8'h00;
      endcase
      return b;
   endfunction

   // APB slave: data is prepared in the first access cycle, committed when pready is seen
   assign apb_access = PSEL_IN & PENABLE_IN;
   assign apb_commit = apb_access & PREADY_OUT;
   assign apb_mapped = PADDR_IN[7:2] <= {1'b0, `IDX_LAST};
   assign apb_idx    = PADDR_IN[6:2];

   always_ff @(posedge CORE_CLK_IN)
   begin
      if (!rst_n)
      begin
         PREADY_OUT  <= 1'b0;
         PSLVERR_OUT <= 1'b0;
         PRDATA_OUT  <= 32'h00000000;
      end
      else if (apb_access && !PREADY_OUT)
      begin
         PREADY_OUT  <= 1'b1;
         PSLVERR_OUT <= ~apb_mapped;
         PRDATA_OUT  <= {24'h000000, apb_mapped ? reg_byte(apb_idx) : 8'h00};
      end
      else
      begin
         PREADY_OUT  <= 1'b0;
         PSLVERR_OUT <= 1'b0;
      end
   end

   // Port 0 is APB, port 1 the serial target; port 1 wins a same-cycle clash on one byte
   assign wr_en[0]  = apb_commit & PWRITE_IN & apb_mapped;
   assign wr_idx[0] = apb_idx;
   assign wr_dat[0] = PWDATA_IN[7:0];
   assign wr_en[1]  = tgt_wr;
   assign wr_idx[1] = tgt_idx;
   assign wr_dat[1] = tgt_dat;
   assign rd_en[0]  = apb_commit & ~PWRITE_IN & apb_mapped;
   assign rd_idx[0] = apb_idx;
   assign rd_dat[0] = PRDATA_OUT[7:0];
   assign rd_en[1]  = tgt_rd;
   assign rd_idx[1] = tgt_idx;
   assign rd_dat[1] = tgt_dat;

   always_ff @(posedge CORE_CLK_IN)
   begin
      if (!rst_n)
      begin
         out_reg  <= 16'h0000;
         pol_reg  <= 16'h0000;
         dir_reg  <= `RST_DIR;
         drv_reg  <= `RST_DRV;
         lat_reg  <= 16'h0000;
         pen_reg  <= 16'h0000;
         psel_reg <= `RST_PSEL;
         msk_reg  <= `RST_MASK;
         od_reg   <= 2'b00;
      end
      else
      begin
         for (int s = 0; s < 2; s++)
         begin
            if (wr_en[s])
            begin
               // Input and status bytes are read-only and fall to the default branch
               case (wr_idx[s])
                  `IDX_OUT0, `IDX_OUT1: out_reg[{wr_idx[s][0], 3'b000} +: 8] <= wr_dat[s];
                  `IDX_POL0, `IDX_POL1: pol_reg[{wr_idx[s][0], 3'b000} +: 8] <= wr_dat[s];
                  `IDX_DIR0, `IDX_DIR1: dir_reg[{wr_idx[s][0], 3'b000} +: 8] <= wr_dat[s];
                  `IDX_DRV0, `IDX_DRV1,
                  `IDX_DRV2, `IDX_DRV3: drv_reg[{wr_idx[s][1:0], 3'b000} +: 8] <= wr_dat[s];
                  `IDX_LAT0, `IDX_LAT1: lat_reg[{wr_idx[s][0], 3'b000} +: 8] <= wr_dat[s];
                  `IDX_PEN0, `IDX_PEN1: pen_reg[{wr_idx[s][0], 3'b000} +: 8] <= wr_dat[s];
                  `IDX_PSEL0, `IDX_PSEL1: psel_reg[{wr_idx[s][0], 3'b000} +: 8] <= wr_dat[s];
                  `IDX_MSK0, `IDX_MSK1: msk_reg[{wr_idx[s][0], 3'b000} +: 8] <= wr_dat[s];
                  `IDX_OCFG:            od_reg <= wr_dat[s][1:0];
                  default:              od_reg <= od_reg;
               endcase
            end
         end
      end
   end

   assign eff  = line_s ^ pol_reg;
   assign diff = eff ^ ref_reg;

   // Per line: input view, latch hold, reference of last read value, pending status
   for (genvar i = 0; i < 16; i++)
   begin : g_line
      localparam reg_idx_t IN_IDX = (i < 8) ? `IDX_IN0 : `IDX_IN1;
      localparam int       BIT    = i % 8;
      logic                rd_hit;
      logic                rd_bit;

      assign rd_hit = (rd_en[0] && rd_idx[0] == IN_IDX) || (rd_en[1] && rd_idx[1] == IN_IDX);
      assign rd_bit = (rd_en[1] && rd_idx[1] == IN_IDX) ? rd_dat[1][BIT] : rd_dat[0][BIT];

      always_ff @(posedge CORE_CLK_IN)
      begin
         if (!rst_n)
         begin
            in_reg[i]   <= 1'b0;
            ref_reg[i]  <= 1'b0;
            hold_reg[i] <= 1'b0;
            sta_reg[i]  <= 1'b0;
         end
         else
         begin
            if (!lat_reg[i] || !hold_reg[i])
               in_reg[i] <= eff[i];
            // A new capture beats a read clearing the hold in the same cycle
            if (lat_reg[i] && !hold_reg[i] && diff[i] && dir_reg[i])
               hold_reg[i] <= 1'b1;
            else if (rd_hit || !lat_reg[i])
               hold_reg[i] <= 1'b0;
            // Masked and output lines track the pin so unmasking an unlatched line raises nothing stale
            if (rd_hit)
               ref_reg[i] <= rd_bit;
            else if (msk_reg[i] || !dir_reg[i])
               ref_reg[i] <= eff[i];
            sta_reg[i] <= dir_reg[i] & ~msk_reg[i] & (lat_reg[i] ? hold_reg[i] : diff[i]);
         end
      end
   end

   always_ff @(posedge CORE_CLK_IN)
   begin
      if (!rst_n)
      begin
         LINE_OUT     <= 16'h0000;
         LINE_OE_OUT  <= 16'h0000;
         DRIVE_OUT    <= `RST_DRV;
         PULL_EN_OUT  <= 16'h0000;
         PULL_UP_OUT  <= `RST_PSEL;
         ALERT_OUT    <= 1'b0;
         ALERT_OE_OUT <= 1'b0;
         SDA_OUT      <= 1'b0;
         SDA_OE_OUT   <= 1'b0;
      end
      else
      begin
         LINE_OUT     <= out_reg;
         // Open-drain banks only enable the driver while pulling low
         LINE_OE_OUT  <= ~dir_reg & ({{8{~od_reg[1]}}, {8{~od_reg[0]}}} | ~out_reg);
         DRIVE_OUT    <= drv_reg;
         PULL_EN_OUT  <= pen_reg;
         PULL_UP_OUT  <= psel_reg;
         ALERT_OUT    <= 1'b0;
         ALERT_OE_OUT <= |sta_reg;
         SDA_OUT      <= 1'b0;
         SDA_OE_OUT   <= tgt_sda_oe;
      end
   end

   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (!rst_n);

   sequence cap1_s;
      lat_reg[1] && !hold_reg[1] && diff[1] && dir_reg[1];
   endsequence
   sequence quiet2_s;
      (!rd_en[0] && !rd_en[1] && !wr_en[0] && !wr_en[1]) [*2];
   endsequence

   por_input_a: assert property (disable iff (1'b0) !RST_B_IN |=> LINE_OE_OUT == 16'h0000)
      else $error("line driven after reset");
   mask_default_a: assert property (disable iff (1'b0) !rst_n |=> msk_reg == `RST_MASK && !ALERT_OE_OUT)
      else $error("mask not set after reset");
   pin_reset_a: assert property (disable iff (1'b0) !pin_rst_s |=> dir_reg == `RST_DIR && out_reg == 16'h0000)
      else $error("reset pin did not default registers");
   dir_apply_a: assert property ((LINE_OE_OUT & $past(dir_reg)) == 16'h0000)
      else $error("input line driven");
   out_value_a: assert property (LINE_OUT == $past(out_reg))
      else $error("output line differs from output register");
   // The input register shows its reset value, not the pin, in the first cycle after reset
   pol_view_a: assert property ($past(rst_n) |->
      ((in_reg ^ $past(eff)) & ~$past(lat_reg | hold_reg)) == 16'h0000)
      else $error("input register does not follow polarity");
   alert_src_a: assert property (ALERT_OE_OUT == |$past(sta_reg) && !ALERT_OUT)
      else $error("alert does not match status");
   latch_hold_a: assert property (cap1_s ##1 quiet2_s |-> hold_reg[1] && $stable(in_reg[1]))
      else $error("latched value not held");
   mask_block_a: assert property ((sta_reg & $past(msk_reg)) == 16'h0000)
      else $error("masked line reported pending");
   od_bank_a: assert property ((LINE_OE_OUT & LINE_OUT & {{8{$past(od_reg[1])}}, {8{$past(od_reg[0])}}}) == 16'h0000)
      else $error("open-drain line driven high");
   drive_pull_a: assert property (DRIVE_OUT == $past(drv_reg) && PULL_EN_OUT == $past(pen_reg))
      else $error("drive or pull setting not applied");
endmodule
`default_nettype wire

// [testbench/serial_master.sv]
// Two-wire bus master model facing the expander's serial target
`include "gpio_exp_params.svh"
`default_nettype none
module serial_master
(
   output logic      scl_out,
   output logic      sda_low_out,
   input  wire logic sda_in
);
   timeunit 1ns / 100ps;
   initial {scl_out, sda_low_out} = 2'h2;
   // Ninth bit is released for the ack; SCL rests high between frames
   task automatic xb(input logic [8:0] v, output logic [8:0] q);
      for (int i = 8; i >= 0; i--)
      begin
         #32 sda_low_out = ~v[i];
         #30 scl_out = 1'h1;
         #31 q[i] = sda_in;
         #32 scl_out = 1'h0;
      end
   endtask
   // Half-step start keeps every wire change off the core clock edges when go is entered on a clock edge
   task automatic go(input logic a, input logic r, output logic ok);
      logic [8:0] q;
      #0.5 sda_low_out = 1'h1;
      #62 scl_out = 1'h0;
      xb({`BUS_ADDR_HI, a, r, 1'h1}, q);
      ok = ~q[0];
   endtask
   task automatic halt;
      sda_low_out = 1'h1;
      #30 scl_out = 1'h1;
      #31 sda_low_out = 1'h0;
      #62;
   endtask
   task automatic wr(input logic a, input logic [7:0] p, input logic [7:0] d, output logic ok);
      logic       k0;
      logic [8:0] q1, q2;
      go(a, 1'h0, k0);
      xb({p, 1'h1}, q1);
      xb({d, 1'h1}, q2);
      halt();
      ok = k0 & ~q1[0] & ~q2[0];
   endtask
   // One byte from the current pointer, ended by a released NACK bit
   task automatic rd(input logic a, output logic [7:0] d, output logic ok);
      logic [8:0] q;
      go(a, 1'h1, ok);
      xb(9'h1FF, q);
      halt();
      d = q[8:1];
      ok = ok & q[0];
   endtask
endmodule
`default_nettype wire

// [testbench/tb_gpio_expander.sv]
// Bench of the I/O expander: APB registers, serial writes, port lines and alert
`include "gpio_exp_params.svh"
`default_nettype none
module tb_gpio_expander;
   timeunit 1ns / 100ps;
   logic        clk = 1'h0, rst_b = 1'h0, sel = 1'h0, en = 1'h0, wr = 1'h0, dev_b = 1'h1, asel = 1'h0, ok;
   logic [7:0]  adr = 8'h00, p, v [24];
   logic [15:0] pins = 16'h0, e;
   logic [31:0] wd = 32'h0, rnd = 32'hBB01;
   logic [32:0] r;
   wire  [31:0] rd, drv;
   wire  [15:0] lo, oe, pe, pu;
   wire         rdy, slv, so, soe, al, aoe, scl, sl;
   wire         sda = ~(sl | soe);
   int          fails = 0, samples_checked = 0;
   always #4 clk = ~clk;
   gpio_expander dut_u (.CORE_CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(sel), .PENABLE_IN(en), .PWRITE_IN(wr),
      .PADDR_IN(adr), .PWDATA_IN(wd), .PRDATA_OUT(rd), .PREADY_OUT(rdy), .PSLVERR_OUT(slv), .DEV_RST_B_IN(dev_b),
      .ADDR_SEL_IN(asel), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(so), .SDA_OE_OUT(soe), .LINE_IN(pins),
      .LINE_OUT(lo), .LINE_OE_OUT(oe), .DRIVE_OUT(drv), .PULL_EN_OUT(pe), .PULL_UP_OUT(pu), .ALERT_OUT(al),
      .ALERT_OE_OUT(aoe));
   serial_master m_u (.scl_out(scl), .sda_low_out(sl), .sda_in(sda));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] rv(input int i);
      return (i inside {[6:11], [16:19]}) ? 8'hFF : 8'h00;
   endfunction
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [95:0] s, input logic [95:0] x, input string w);
      samples_checked++;
      fails += (s !== x);
      if (s !== x)
         $display("CHECK FAILED %s expected %h seen %h", w, x, s);
   endtask
   task automatic apb(input logic w, input int i, input logic [7:0] d);
      int n;
      sel <= 1'h1;
      wr <= w;
      adr <= 8'(i * 4);
      wd <= {rnd[31:8], d};
      @(posedge clk);
      en <= 1'h1;
      for (n = 0; n < 20 && rdy !== 1'h1; n++)
         @(posedge clk);
      r = {slv, rd};
      sel <= 1'h0;
      en <= 1'h0;
      @(posedge clk);
      fails += (n == 20);
      if (n == 20)
         give_verdict();
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      rst_b <= 1'h1;
      repeat (4) @(posedge clk);
      chk({oe, so, al, aoe, pu, drv}, {19'h0, 16'hFFFF, `RST_DRV}, "reset pins");
      // Masks stay set so the status bytes must read zero here
      for (int i = 0; i < 24; i++)
      begin
         apb(1'h0, i, 8'h00);
         chk(r, {i == 23, 24'h0, rv(i)}, "reset");
         rnd = lfsr(rnd);
         v[i] = (i == 22) ? {6'h0, rnd[1:0]} : (i inside {18, 19}) ? 8'hFF : rnd[7:0];
         apb(1'h1, i, v[i]);
         ok = r[32];
         apb(1'h0, i, 8'h00);
         chk({ok, r}, {i == 23, i == 23, 24'h0, (i inside {0, 1, 20, 21, 23}) ? 8'h00 : v[i]}, "rdback");
      end
      e = ~{v[7], v[6]} & ~{v[22][1] ? v[3] : 8'h00, v[22][0] ? v[2] : 8'h00};
      chk({drv, pe, pu}, {v[11], v[10], v[9], v[8], v[15], v[14], v[17], v[16]}, "cfg");
      chk({oe, lo & e}, {e, {v[3], v[2]} & e}, "outputs");
      asel <= rnd[0];
      repeat (4) @(posedge clk);
      m_u.wr(rnd[0], 8'h02, rnd[15:8], ok);
      chk(ok, 1'h1, "ack");
      m_u.wr(~rnd[0], 8'h02, 8'h5A, ok);
      chk(ok, 1'h0, "foreign");
      @(posedge clk);
      // The data byte moved the pointer past OUT0, so this reads OUT1
      m_u.rd(rnd[0], p, ok);
      chk({ok, p}, {1'h1, v[3]}, "serial read");
      @(posedge clk);
      apb(1'h0, 2, 8'h00);
      chk(r, rnd[15:8], "serial");
      dev_b <= 1'h0;
      repeat (2) @(posedge clk);
      dev_b <= 1'h1;
      repeat (5) @(posedge clk);
      apb(1'h0, 6, 8'h00);
      chk({r, oe}, {33'hFF, 16'h0}, "pin reset");
      p = rnd[23:16];
      apb(1'h1, 4, p);
      apb(1'h1, 18, 8'hFC);
      apb(1'h1, 12, 8'h02);
      apb(1'h0, 0, 8'h00);
      chk(r, p, "invert");
      pins <= 16'h0103;
      for (int n = 0; n < 10 && aoe !== 1'h1; n++)
         @(posedge clk);
      fails += (aoe !== 1'h1);
      if (aoe !== 1'h1)
         give_verdict();
      chk({aoe, al}, 2'h2, "alert");
      apb(1'h0, 20, 8'h00);
      chk(r, 8'h03, "status");
      apb(1'h0, 21, 8'h00);
      chk(r, 8'h00, "masked");
      pins <= 16'h0;
      repeat (6) @(posedge clk);
      apb(1'h0, 0, 8'h00);
      chk(r, p ^ 8'h02, "latched");
      apb(1'h0, 0, 8'h00);
      repeat (6) @(posedge clk);
      chk({r, aoe}, {25'h0, p, 1'h0}, "cleared");
      give_verdict();
   end
endmodule
`default_nettype wire
